// [rtl/dcfs_flag_select.sv]
// Purpose: compute the dsp condition flag after each alu or shift operation
// Assumes: execution unit gives result, carry, last shifted bit, guard over-range
// Assumes: at most one reported operation per clock, its inputs valid in that cycle
// Notes: flag holds its value when no operation is reported
// Notes: select codes 110 and 111 name no mode and also hold the flag
// Notes: the flag appears one clock after the operation is taken
`timescale 1ns/10ps

// What this block does
// - in carry mode (000) an arithmetic op sets the flag on carry or borrow, else clears it.
// - in carry mode a shift loads the flag with the last bit shifted out.
// - in carry mode a logical op always clears the flag.
// - in negative mode arithmetic ops and arithmetic shifts copy the result msb with guard bits.
// - in negative mode logical ops and logical shifts copy the result msb without guard bits.
// - in zero mode the flag is set when the result is all zeros, else cleared.
// - in overflow mode (011) arithmetic results beyond the range without guard bits set the flag.
// - in overflow, greater-than and greater-or-equal modes logical ops and logical shifts clear the flag.
// - in greater-or-equal mode (101) the flag is not(negative xor over-range incl guard bits).
// - in greater-than mode the flag is not(zero or (negative xor over-range)).
// - select value 100 chooses greater-than mode.
module dcfs_flag_select
    import dcfs_pkg::*;
#(
    parameter int RES_W   = RESULT_WIDTH,
    parameter int GUARD_W = GUARD_WIDTH
)
(
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    input  wire logic                 op_valid,
    input  wire dcfs_op_type          op_class,
    input  wire logic [SEL_WIDTH-1:0] cond_sel,
    input  wire logic [RES_W-1:0]     result,
    input  wire logic                 carry_borrow,
    input  wire logic                 shift_out_bit,
    input  wire logic                 over_range_guard,
    output logic                      dsp_condition_flag
);
    typedef struct packed {
        logic flag;
    } dcfs_state_type;

    dcfs_state_type state;
    dcfs_state_type next_state;

    logic is_zero;
    logic msb_with_guard;
    logic msb_no_guard;
    logic over_no_guard;

    // result decode
    dcfs_result_decode #(
        .RES_W   (RES_W),
        .GUARD_W (GUARD_W)
    ) u_decode (
        .result         (result),
        .is_zero        (is_zero),
        .msb_with_guard (msb_with_guard),
        .msb_no_guard   (msb_no_guard),
        .over_no_guard  (over_no_guard)
    );

    // class of the reported operation, seen by several modes
    typedef struct packed {
        logic taken;
        logic arith_like;
        logic shift;
        logic plain_arith;
    } dcfs_class_type;

    dcfs_class_type op_kind;

    // arithmetic-style class: arithmetic ops and arithmetic shifts
    function automatic logic is_arith_like(input dcfs_op_type c);
        return (c == DCFS_OP_ARITH) || (c == DCFS_OP_ASHIFT);
    endfunction : is_arith_like

    // shifts of either kind
    function automatic logic is_shift(input dcfs_op_type c);
        return (c == DCFS_OP_ASHIFT) || (c == DCFS_OP_LSHIFT);
    endfunction : is_shift

    // one decode of the class for every mode
    function automatic dcfs_class_type decode_class(input logic        valid,
                                                    input dcfs_op_type c);
        dcfs_class_type k;
        k.taken       = valid && (c != DCFS_OP_NONE);
        k.arith_like  = is_arith_like(c);
        k.shift       = is_shift(c);
        k.plain_arith = (c == DCFS_OP_ARITH);
        return k;
    endfunction : decode_class

    // carry mode: a shift wins over the logical clear
    function automatic logic carry_mode_value(input dcfs_class_type k,
                                              input logic           cb,
                                              input logic           sb);
        logic value;
        value = 1'h0;
        if (k.shift)
        begin
            value = sb;
        end
        else if (k.plain_arith)
        begin
            value = cb;
        end
        return value;
    endfunction : carry_mode_value

    // negative mode: guard bits count for arithmetic-style results only
    function automatic logic neg_mode_value(input dcfs_class_type k,
                                            input logic           top_guard,
                                            input logic           top_base);
        logic value;
        if (k.arith_like)
        begin
            value = top_guard;
        end
        else
        begin
            value = top_base;
        end
        return value;
    endfunction : neg_mode_value

    // overflow mode: range judged without guard bits, logical work clears
    function automatic logic ovf_mode_value(input dcfs_class_type k,
                                            input logic           over_base);
        logic value;
        value = 1'h0;
        if (k.arith_like)
        begin
            value = over_base;
        end
        return value;
    endfunction : ovf_mode_value

    // greater-than mode: greater-or-equal that also drops an all-zero result
    function automatic logic gt_mode_value(input dcfs_class_type k,
                                           input logic           sign_term,
                                           input logic           zero);
        logic value;
        value = 1'h0;
        if (k.arith_like)
        begin
            value = !(sign_term || zero);
        end
        return value;
    endfunction : gt_mode_value

    // greater-or-equal mode: negative xor over-range, inverted
    function automatic logic ge_mode_value(input dcfs_class_type k,
                                           input logic           sign_term);
        logic value;
        value = 1'h0;
        if (k.arith_like)
        begin
            value = !sign_term;
        end
        return value;
    endfunction : ge_mode_value

    logic signed_term;
    logic carry_mode_flag;
    logic neg_mode_flag;
    logic zero_mode_flag;
    logic ovf_mode_flag;
    logic gt_mode_flag;
    logic ge_mode_flag;

    // class decode, shared by all modes
    assign op_kind = decode_class(op_valid, op_class);

    // negative xor over-range, over-range counting the guard bits
    assign signed_term = msb_with_guard ^ over_range_guard;

    // candidate flag of every condition mode
    assign carry_mode_flag = carry_mode_value(op_kind, carry_borrow, shift_out_bit);
    assign neg_mode_flag   = neg_mode_value(op_kind, msb_with_guard, msb_no_guard);
    assign zero_mode_flag  = is_zero;
    assign ovf_mode_flag   = ovf_mode_value(op_kind, over_no_guard);
    assign gt_mode_flag    = gt_mode_value(op_kind, signed_term, is_zero);
    assign ge_mode_flag    = ge_mode_value(op_kind, signed_term);

    // flag selection; idle cycles and unused select codes hold the flag
    always_comb
    begin
        next_state = state;
        if (op_kind.taken)
        begin
            case (cond_sel)
                SEL_CARRY:
                    next_state.flag = carry_mode_flag;
                SEL_NEG:
                    next_state.flag = neg_mode_flag;
                SEL_ZERO:
                    next_state.flag = zero_mode_flag;
                SEL_OVF:
                    next_state.flag = ovf_mode_flag;
                SEL_GT:
                    next_state.flag = gt_mode_flag;
                SEL_GE:
                    next_state.flag = ge_mode_flag;
                default:
                    next_state.flag = state.flag;
            endcase
        end
    end

    // state register; the flag is cleared while reset is low
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= '{flag: FLAG_RESET};
        else
            state <= next_state;
    end

    // the flag stands until the next taken operation
    assign dsp_condition_flag = state.flag;
endmodule : dcfs_flag_select

// [rtl/dcfs_pkg.sv]
// Purpose: shared constants for the dsp condition flag select block
// Assumes: 40-bit results, 8 guard bits above a 32-bit register range
// Notes: operation class and condition select encodings
package dcfs_pkg;
    localparam int RESULT_WIDTH = 40;
    localparam int GUARD_WIDTH  = 8;
    localparam int SEL_WIDTH    = 3;

    // condition select encodings
    localparam logic [2:0] SEL_CARRY   = 3'h0;
    localparam logic [2:0] SEL_NEG     = 3'h1;
    localparam logic [2:0] SEL_ZERO    = 3'h2;
    localparam logic [2:0] SEL_OVF     = 3'h3;
    localparam logic [2:0] SEL_GT      = 3'h4;
    localparam logic [2:0] SEL_GE      = 3'h5;

    // class of the operation that produced the result
    typedef enum logic [2:0] {
        DCFS_OP_NONE      = 3'h0,
        DCFS_OP_ARITH     = 3'h1,
        DCFS_OP_LOGIC     = 3'h3,
        DCFS_OP_ASHIFT    = 3'h2,
        DCFS_OP_LSHIFT    = 3'h6
    } dcfs_op_type;

    localparam logic FLAG_RESET = 1'h0;
endpackage : dcfs_pkg

// [rtl/dcfs_result_decode.sv]
// Purpose: derive zero, negative and over-range terms from a result
// Assumes: result arrives with guard bits in the top GUARD_W bits
// Notes: purely combinational
`timescale 1ns/10ps
module dcfs_result_decode
    import dcfs_pkg::*;
#(
    parameter int RES_W   = RESULT_WIDTH,
    parameter int GUARD_W = GUARD_WIDTH
)
(
    input  wire logic [RES_W-1:0] result,
    output logic                  is_zero,
    output logic                  msb_with_guard,
    output logic                  msb_no_guard,
    output logic                  over_no_guard
);
    localparam int BASE_W = RES_W - GUARD_W;

    // sign bits and all-zero test
    assign is_zero        = (result == '0);
    assign msb_with_guard = result[RES_W-1];
    assign msb_no_guard   = result[BASE_W-1];
    // guard bits differing from the base sign means out of range
    assign over_no_guard  = (result[RES_W-1:BASE_W-1] != '0) &&
                            (result[RES_W-1:BASE_W-1] != '1);
endmodule : dcfs_result_decode

// [test/dcfs_flag_select_sva.sv]
// Purpose: assertions on the condition flag of the flag select block
// Assumes: flag follows a taken operation by one cycle
// Notes: bound to the top module
`timescale 1ns/10ps
module dcfs_flag_select_sva
    import dcfs_pkg::*;
#(parameter int RES_W = RESULT_WIDTH, parameter int GUARD_W = GUARD_WIDTH)
(
    input logic                 ref_clk,
    input logic                 rst_n,
    input logic                 op_valid,
    input dcfs_op_type          op_class,
    input logic [SEL_WIDTH-1:0] cond_sel,
    input logic [RES_W-1:0]     result,
    input logic                 carry_borrow,
    input logic                 shift_out_bit,
    input logic                 over_range_guard,
    input logic                 dsp_condition_flag
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // taken mode one-hot and expected result terms
    wire tk = op_valid && op_class != DCFS_OP_NONE;
    wire [7:0] m = {7'h0, tk} << cond_sel;
    wire ar = op_class inside {DCFS_OP_ARITH, DCFS_OP_ASHIFT};
    wire lg = op_class inside {DCFS_OP_LOGIC, DCFS_OP_LSHIFT};
    wire [GUARD_W:0] hi = result[RES_W-1:RES_W-GUARD_W-1];
    wire ng = result[RES_W-1];
    wire nx = ar ? ng : result[RES_W-GUARD_W-1];
    wire zr = result == '0;
    wire ov = !(&hi || !(|hi));
    wire ge = !(ng ^ over_range_guard);
    wire f = dsp_condition_flag;
    wire pa = op_class == DCFS_OP_ARITH;
    wire sh = op_class inside {DCFS_OP_ASHIFT, DCFS_OP_LSHIFT};
    wire lo = op_class == DCFS_OP_LOGIC;
    // flag one cycle after each operation
    a_carry_arith: assert property (m[0] && pa |=> f == $past(carry_borrow))
        else $error("carry flag wrong");
    a_carry_shift: assert property (m[0] && sh |=> f == $past(shift_out_bit))
        else $error("shift carry flag wrong");
    a_carry_logic: assert property (m[0] && lo |=> !f)
        else $error("logic carry flag set");
    a_neg_mode: assert property (m[1] |=> f == $past(nx))
        else $error("negative flag wrong");
    a_zero_mode: assert property (m[2] |=> f == $past(zr))
        else $error("zero flag wrong");
    a_ovf_mode: assert property (m[3] && ar |=> f == $past(ov))
        else $error("overflow flag wrong");
    a_logic_clear: assert property (|m[5:3] && lg |=> !f)
        else $error("flag not cleared");
    a_ge_mode: assert property (m[5] && ar |=> f == $past(ge))
        else $error("ge flag wrong");
    a_gt_mode: assert property (m[4] && pa |=> f == $past(ge && !zr))
        else $error("gt flag wrong");
    a_flag_hold: assert property (!(|m[5:0]) |=> $stable(f))
        else $error("flag moved without operation");
endmodule : dcfs_flag_select_sva
bind dcfs_flag_select dcfs_flag_select_sva #(.RES_W(RES_W), .GUARD_W(GUARD_W)) u_sva (
    .ref_clk            (ref_clk),
    .rst_n              (rst_n),
    .op_valid           (op_valid),
    .op_class           (op_class),
    .cond_sel           (cond_sel),
    .result             (result),
    .carry_borrow       (carry_borrow),
    .shift_out_bit      (shift_out_bit),
    .over_range_guard   (over_range_guard),
    .dsp_condition_flag (dsp_condition_flag)
);

// [test/dcfs_flag_select_tb.sv]
// Purpose: self-checking bench for the condition flag select block
// Assumes: flag valid one cycle after each operation
// Notes: table rows, then a mid-run reset
`timescale 1ns/10ps
module dcfs_flag_select_tb
    import dcfs_pkg::*;
;
    // row: class, select, result, {valid, carry, shifted, over-range, expected}
    typedef struct packed {logic [2:0] c; logic [2:0] s;
                           logic [39:0] r; logic [4:0] f;} dcfs_row_type;
    logic ref_clk = 1'h0, rst_n = 1'h0, op_valid = 1'h0, dsp_condition_flag;
    logic carry_borrow = 1'h0, shift_out_bit = 1'h0, over_range_guard = 1'h0;
    logic [SEL_WIDTH-1:0] cond_sel = 3'h0;
    logic [RESULT_WIDTH-1:0] result = 40'h0;
    dcfs_op_type op_class = DCFS_OP_NONE;
    int n_fail = 0, checks_done = 0;
    dcfs_row_type rows [28] = '{
        '{3'h1,3'h0,40'h0,5'h19}, '{3'h1,3'h0,40'h0,5'h10}, '{3'h6,3'h0,40'h0,5'h15},
        '{3'h3,3'h0,40'h0,5'h1C}, '{3'h2,3'h0,40'h0,5'h15}, '{3'h1,3'h0,40'h0,5'h01},
        '{3'h0,3'h0,40'h0,5'h11}, '{3'h1,3'h6,40'h0,5'h11}, '{3'h1,3'h1,40'h8000000000,5'h11},
        '{3'h3,3'h1,40'h8000000000,5'h10}, '{3'h6,3'h1,40'h0080000000,5'h11},
        '{3'h3,3'h2,40'h0,5'h11}, '{3'h1,3'h2,40'h0100000000,5'h10},
        '{3'h1,3'h3,40'h0080000000,5'h11}, '{3'h1,3'h3,40'hFF80000000,5'h10},
        '{3'h2,3'h3,40'h0080000000,5'h11}, '{3'h6,3'h3,40'h0080000000,5'h10},
        '{3'h1,3'h5,40'h0,5'h11}, '{3'h3,3'h5,40'h0,5'h10}, '{3'h2,3'h5,40'h8000000000,5'h13},
        '{3'h1,3'h5,40'h8000000000,5'h10}, '{3'h1,3'h4,40'h1,5'h11}, '{3'h1,3'h4,40'h0,5'h10},
        '{3'h1,3'h4,40'h8000000000,5'h13}, '{3'h6,3'h5,40'h0,5'h10}, '{3'h3,3'h4,40'h1,5'h10},
        '{3'h1,3'h4,40'h1,5'h11}, '{3'h1,3'h7,40'h0,5'h11}};
    dcfs_flag_select DUT (
        .ref_clk            (ref_clk),
        .rst_n              (rst_n),
        .op_valid           (op_valid),
        .op_class           (op_class),
        .cond_sel           (cond_sel),
        .result             (result),
        .carry_borrow       (carry_borrow),
        .shift_out_bit      (shift_out_bit),
        .over_range_guard   (over_range_guard),
        .dsp_condition_flag (dsp_condition_flag)
    );
    wire flag = dsp_condition_flag;
    // clock and cycle ceiling
    always #5 ref_clk = ~ref_clk;
    initial
    begin
        repeat (200) @(posedge ref_clk);
        n_fail++;
        stop_test();
    end
    task automatic chk(input string nm, input logic e, input logic s);
        checks_done++;
        if (s !== e)
            $display("mismatch %s expected %b seen %b", nm, e, s);
        if (s !== e)
            n_fail++;
    endtask : chk
    task automatic stop_test();
        if (n_fail == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    // table rows, then reset in mid-run with the flag set
    initial
    begin
        repeat (10) @(posedge ref_clk);
        chk("reset flag", 1'h0, dsp_condition_flag);
        rst_n <= 1'h1;
        foreach (rows[i])
        begin
            @(posedge ref_clk);
            op_class <= dcfs_op_type'(rows[i].c);
            cond_sel <= rows[i].s;
            result <= rows[i].r;
            {op_valid, carry_borrow, shift_out_bit, over_range_guard} <= rows[i].f[4:1];
            repeat (2) @(negedge ref_clk);
            chk("flag", rows[i].f[0], flag);
        end
        // reset in mid-run, then an operation at the first edge after release
        @(posedge ref_clk);
        rst_n <= 1'h0;
        op_valid <= 1'h0;
        #2;
        chk("mid reset flag", 1'h0, flag);
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'h1;
        op_class <= DCFS_OP_ARITH;
        cond_sel <= SEL_CARRY;
        {op_valid, carry_borrow} <= 2'h3;
        @(negedge ref_clk);
        chk("flag after release", 1'h0, flag);
        @(negedge ref_clk);
        chk("first op after release", 1'h1, flag);
        stop_test();
    end
endmodule : dcfs_flag_select_tb
